/* File: hdl/pms_pkg.sv */
// Package for the power mode sequencer: modes, domain sets, timing counts.
// Assumes a single 100 MHz clock and synchronous active-high reset.
//
// Function
// R1: Request high, supplies good: full working mode
// R2: Request low: save state, RF/baseband off
// R3: Request high again: resume full mode, hot
// R4: Auto mode after fix: sleep, start wake timer
// R5: Wake timer expiry: resume for next fix
// R6: Only backup supply: keep RTC and RAM
// R7: Backup RAM survives for hot start
// R8: No backup supply and POR loss: lose RAM
// R9: Internal power-on reset plus external reset input
// R10: Synchronise and filter request pin before use
package pms_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS   = 10;                    // Clock period
   localparam int FILTER_TIME_NS  = 200;                   // Request stable time
   localparam int FILTER_CYCLES   = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_CNT_W      = 5;                     // Filter counter width
   localparam int POR_TIME_NS     = 1000;                  // Internal reset stretch
   localparam int POR_CYCLES      = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_CNT_W       = 7;                     // Power-on counter width
   localparam int WAKE_CNT_W      = 32;                    // Wake timer width
   localparam logic [WAKE_CNT_W-1:0] WAKE_DEFAULT = 32'h0000_1000; // Default wake period
   localparam int SAVE_CYCLES     = 4;                     // State save duration
   localparam int SAVE_CNT_W      = 3;                     // Save counter width

   // ****************************************************************
   // Modes
   // ****************************************************************
   typedef enum logic [2:0] {
      PMS_RESET  = 3'h0,   // Held in reset
      PMS_FULL   = 3'h1,   // Full working
      PMS_SAVE   = 3'h2,   // Saving state before sleep
      PMS_EXTLP  = 3'h3,   // Externally requested low power
      PMS_AUTOLP = 3'h4,   // Automatic low power, timer running
      PMS_BACKUP = 3'h5    // Battery backup
   } pms_mode_type;

   // Domain enables
   typedef struct packed {
      logic rf;            // RF front-end
      logic bb;            // Baseband core
      logic io;            // IO and power-on reset domain
      logic rtc;           // RTC and backup RAM
   } pms_dom_type;

   // Supply good indications
   typedef struct packed {
      logic main;          // Main supplies present
      logic backup;        // Backup supply present
   } pms_sup_type;

   localparam pms_dom_type DOM_ALL  = 4'hF;  // Every domain on
   localparam pms_dom_type DOM_LP   = 4'h3;  // IO and RTC only
   localparam pms_dom_type DOM_BK   = 4'h1;  // RTC only
   localparam pms_dom_type DOM_NONE = 4'h0;  // Everything off

   // Domain set per mode
   function automatic pms_dom_type dom_of(input pms_mode_type m);
      case (m)
         PMS_FULL, PMS_SAVE:   dom_of = DOM_ALL;
         PMS_EXTLP, PMS_AUTOLP: dom_of = DOM_LP;
         PMS_BACKUP:           dom_of = DOM_BK;
         default:              dom_of = DOM_NONE;
      endcase
   endfunction : dom_of

endpackage : pms_pkg

/* File: hdl/pms_req_filter.sv */
// Two-flop synchroniser and stability filter for the power request pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module pms_req_filter
   import pms_pkg::*;
(
   input  wire logic ref_clk,   // System clock
   input  wire logic srst,      // Synchronous reset
   input  wire logic pinAsync,  // Raw pin level
   output logic      levelQ     // Filtered level
);

   // ****************************************************************
   // Synchroniser and filter
   // ****************************************************************
   logic                  meta_q;  // First stage, read only by sync_q
   logic                  sync_q;  // Second stage
   logic [FILT_CNT_W-1:0] cnt_q;   // Stability counter
   wire                   differ = (sync_q != levelQ);
   wire                   done   = (cnt_q == FILT_CNT_W'(FILTER_CYCLES - 1));

   // Sample pin and qualify its level [R10]
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         cnt_q  <= '0;
         levelQ <= 1'b1;
      end else begin
         meta_q <= pinAsync;
         sync_q <= meta_q;
         cnt_q  <= (differ && !done) ? cnt_q + 1'b1 : '0;   // [R10]
         if (differ && done) begin
            levelQ <= sync_q;                                // [R10]
         end
      end
   end

   // Change only after a full stable run of the synchronised pin
   a_filter_stable: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
      (levelQ != $past(levelQ)) |->
         $past(sync_q) == levelQ && $past(cnt_q) == FILT_CNT_W'(FILTER_CYCLES - 1))
      else $error("filtered level changed without stable input");

endmodule : pms_req_filter
`default_nettype wire

/* File: hdl/power_mode_sequencer.sv */
// Power mode sequencer: picks the operating mode and drives domain enables.
// Assumes supply-good levels and pins are asynchronous; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module power_mode_sequencer
   import pms_pkg::*;
(
   input  wire logic                  ref_clk,            // System clock
   input  wire logic                  srst,               // Synchronous reset
   input  wire logic                  powerReq,           // Host power request pin
   input  wire logic                  external_reset_input_n, // External reset pin, low active
   input  wire logic                  mainSupplyGood,     // Main supplies present
   input  wire logic                  backup_supply,      // Backup supply present
   input  wire logic                  autoLpEnable,       // Automatic low power selected
   input  wire logic                  fixDone,            // Position obtained pulse
   input  wire logic [WAKE_CNT_W-1:0] wakePeriod,         // Wake timer reload
   output pms_dom_type                domEn,              // Domain enables
   output pms_mode_type               modeQ,              // Current mode
   output logic                       saveStrobe,         // Save state request
   output logic                       hotStart,           // Resume from retained state
   output logic                       retainValid,        // Backup RAM contents valid
   output logic                       coreRstN            // Core reset, low active
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   pms_sup_type      supMeta_q;   // First stage, read only below
   pms_sup_type      sup_q;       // Synchronised supplies
   logic             rstMeta_q;   // First stage of reset pin
   logic             rstN_q;      // Synchronised reset pin
   logic             reqLevel;    // Filtered request level

   // Two flops for supplies and reset pin
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         supMeta_q <= '0;
         sup_q     <= '0;
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         supMeta_q <= {mainSupplyGood, backup_supply};
         sup_q     <= supMeta_q;
         rstMeta_q <= external_reset_input_n;
         rstN_q    <= rstMeta_q;
      end
   end

   // Request pin filter
   pms_req_filter uFilt (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .pinAsync (powerReq),
      .levelQ   (reqLevel)
   );

   // ****************************************************************
   // Internal power-on reset
   // ****************************************************************
   logic [POR_CNT_W-1:0] porCnt_q;   // Reset stretch counter
   wire  porDone  = (porCnt_q == POR_CNT_W'(POR_CYCLES));
   wire  anyReset = !porDone || !rstN_q;   // [R9]

   // Stretch reset after srst, main loss or external pin [R9]
   always_ff @(posedge ref_clk) begin
      if (srst || !rstN_q || !sup_q.main) begin
         porCnt_q <= '0;
      end else if (!porDone) begin
         porCnt_q <= porCnt_q + 1'b1;
      end
   end

   // ****************************************************************
   // Wake timer and save counter
   // ****************************************************************
   logic [WAKE_CNT_W-1:0] wake_q;   // RTC wake countdown
   logic [SAVE_CNT_W-1:0] save_q;   // Save phase counter
   logic                  auto_q;   // Sleep is automatic
   wire  wakeExp  = (modeQ == PMS_AUTOLP) && (wake_q == '0);
   wire  saveDone = (save_q == SAVE_CNT_W'(SAVE_CYCLES - 1));

   // ****************************************************************
   // Mode decision
   // ****************************************************************
   pms_mode_type modeD;
   logic         retainD;
   always_comb begin
      modeD   = modeQ;
      retainD = retainValid;
      if (!sup_q.main) begin
         modeD   = sup_q.backup ? PMS_BACKUP : PMS_RESET;   // [R6]
         retainD = retainValid && sup_q.backup;             // [R8]
      end else if (anyReset) begin
         modeD = PMS_RESET;                                 // [R9]
      end else begin
         case (modeQ)
            PMS_RESET, PMS_BACKUP: modeD = reqLevel ? PMS_FULL : PMS_EXTLP; // [R1] [R7]
            PMS_FULL: begin
               if (!reqLevel) begin
                  modeD = PMS_SAVE;                         // [R2]
               end else if (autoLpEnable && fixDone) begin
                  modeD = PMS_SAVE;                         // [R4]
               end
            end
            PMS_SAVE: begin
               if (saveDone) begin
                  modeD   = auto_q ? PMS_AUTOLP : PMS_EXTLP; // [R2] [R4]
                  retainD = 1'b1;
               end
            end
            PMS_EXTLP:  modeD = reqLevel ? PMS_FULL : PMS_EXTLP; // [R3]
            PMS_AUTOLP: begin
               if (!reqLevel) begin
                  modeD = PMS_EXTLP;
               end else if (wakeExp) begin
                  modeD = PMS_FULL;                         // [R5]
               end
            end
            default: modeD = PMS_RESET;
         endcase
      end
   end

   wire enterSave = (modeQ == PMS_FULL) && (modeD == PMS_SAVE);
   wire resumeHot = (modeD == PMS_FULL) && (modeQ != PMS_FULL) && retainD;

   // Mode register and outputs
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         modeQ       <= PMS_RESET;
         domEn       <= DOM_NONE;
         retainValid <= 1'b0;
         saveStrobe  <= 1'b0;
         hotStart    <= 1'b0;
         coreRstN    <= 1'b0;
      end else begin
         modeQ       <= modeD;
         domEn       <= dom_of(modeD);                      // [R1] [R6]
         retainValid <= retainD;                            // [R7] [R8]
         saveStrobe  <= enterSave;                          // [R2]
         hotStart    <= resumeHot;                          // [R3] [R7]
         coreRstN    <= !anyReset && sup_q.main;            // [R9]
      end
   end

   // Timer and save counters
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wake_q <= '0;
         save_q <= '0;
         auto_q <= 1'b0;
      end else begin
         if (enterSave) begin
            auto_q <= reqLevel;                             // [R4]
         end
         save_q <= (modeQ == PMS_SAVE) ? save_q + 1'b1 : '0;
         if (modeQ == PMS_SAVE) begin
            wake_q <= (wakePeriod == '0) ? WAKE_DEFAULT : wakePeriod; // [R4]
         end else if (modeQ == PMS_AUTOLP && wake_q != '0) begin
            wake_q <= wake_q - 1'b1;                        // [R5]
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Domain sets per mode
   a_full_domains: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
      (modeQ == PMS_FULL) |-> domEn == DOM_ALL)
      else $error("full mode without all domains");
   a_lp_domains: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
      (modeQ == PMS_EXTLP || modeQ == PMS_AUTOLP) |-> domEn == DOM_LP)
      else $error("low power mode with wrong domains");

   // Host request: save on fall, resume on rise
   a_req_low_save: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
      (modeQ == PMS_FULL && !reqLevel && sup_q.main && !anyReset) |=> modeQ == PMS_SAVE && saveStrobe)
      else $error("request low did not start save");
   a_req_high_wake: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
      (modeQ == PMS_EXTLP && reqLevel && sup_q.main && !anyReset) |=> modeQ == PMS_FULL)
      else $error("request high did not resume");

   // Automatic sleep and timed wake
   a_auto_sleep: assert property (@(posedge ref_clk) disable iff (srst) // [R4]
      (modeQ == PMS_SAVE && saveDone && auto_q && sup_q.main && !anyReset) |=> modeQ == PMS_AUTOLP)
      else $error("automatic sleep not entered");
   a_wake_expire: assert property (@(posedge ref_clk) disable iff (srst) // [R5]
      (wakeExp && reqLevel && sup_q.main && !anyReset) |=> modeQ == PMS_FULL)
      else $error("wake timer did not resume");

   // Supply loss and retention
   a_backup_domains: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
      (modeQ == PMS_BACKUP) |-> domEn == DOM_BK && retainValid == $past(retainValid))
      else $error("backup mode domains wrong");
   a_rtc_kept: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
      (modeQ != PMS_RESET) |-> domEn.rtc)
      else $error("clock domain off while powered");
   a_retain_lost: assert property (@(posedge ref_clk) disable iff (srst) // [R8]
      (!sup_q.main && !sup_q.backup) |=> !retainValid)
      else $error("retained data survived total loss");
   a_hot_pulse: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
      hotStart |-> modeQ == PMS_FULL && retainValid)
      else $error("hot start without retained state");

   // Reset handling
   a_ext_reset: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
      (!rstN_q && sup_q.main) |=> !coreRstN && modeQ == PMS_RESET)
      else $error("external reset not applied");
   a_full_core: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
      (modeQ == PMS_FULL) |-> coreRstN)
      else $error("full mode while core held in reset");

   // Save strobe only on entry from full working
   a_save_strobe: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
      saveStrobe |-> modeQ == PMS_SAVE && $past(modeQ) == PMS_FULL)
      else $error("save strobe outside save entry");

   // Main scenarios reached
   c_ext_lp: cover property (@(posedge ref_clk) modeQ == PMS_EXTLP ##1 modeQ == PMS_FULL);
   c_auto_cycle: cover property (@(posedge ref_clk) modeQ == PMS_AUTOLP ##1 modeQ == PMS_FULL);
   c_backup_hot: cover property (@(posedge ref_clk) modeQ == PMS_BACKUP ##[1:300] hotStart);
   c_ext_reset: cover property (@(posedge ref_clk) $fell(rstN_q) ##[1:300] coreRstN);

endmodule : power_mode_sequencer
`default_nettype wire

/* File: sim/pms_host_model.sv */
// Host model: drives the power request pin of the sequencer.
// Assumes the bench gives wanted level and glitch commands on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module pms_host_model
(
   input  wire logic       ref_clk,   // System clock
   input  wire logic       runReq,    // Wanted pin level, high = run
   input  wire logic [7:0] glitchLen, // Glitch length in cycles, 0 = none
   output logic            powerReq   // Pin level seen by the device
);
   logic [7:0] glitchQ = 8'h00;       // Remaining glitch cycles

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // Low asks for sleep; a glitch inverts the pin for a short while
   always_ff @(posedge ref_clk) begin
      if (glitchLen != 8'h00) begin
         glitchQ <= glitchLen;
      end else if (glitchQ != 8'h00) begin
         glitchQ <= glitchQ - 8'h01;
      end
   end
   assign powerReq = runReq ^ (glitchQ != 8'h00);
endmodule : pms_host_model
`default_nettype wire

/* File: sim/power_mode_sequencer_tb.sv */
// Self-checking bench for the power mode sequencer.
// Assumes a 100 MHz clock; the host model drives the request pin.
`timescale 1ns/1ns
`default_nettype none
module power_mode_sequencer_tb
   import pms_pkg::*;
;
   logic ref_clk = 1'b0, srst = 1'b1, runReq = 1'b1, extRstN = 1'b1;
   logic mainGood = 1'b1, bkGood = 1'b1, autoLp = 1'b0, fixDone = 1'b0;
   logic [7:0] glitchLen = 8'h00;           // Glitch command
   logic [WAKE_CNT_W-1:0] wakePeriod = 32'h0000_0032; // Wake reload, 50
   logic powerReq, saveStrobe, hotStart, retainValid, coreRstN;
   pms_dom_type  domEn;                      // Domain enables
   pms_mode_type modeQ;                      // Mode seen
   int err_count = 0, samples_checked = 0;   // Report counters
   int hotCnt = 0, saveCnt = 0, n, i, h0, s0; // Pulse counts and scratch
   typedef struct { logic run, main, bk, ret; pms_mode_type mode;
                    pms_dom_type dom; int hot, save; } pms_row_type;
   pms_row_type rows [7] = '{
      '{1'b1,1'b1,1'b1,1'b0,PMS_FULL,  DOM_ALL, 0,0},  // Power up
      '{1'b0,1'b1,1'b1,1'b1,PMS_EXTLP, DOM_LP,  0,1},  // Host sleep
      '{1'b1,1'b1,1'b1,1'b1,PMS_FULL,  DOM_ALL, 1,0},  // Host wake, hot
      '{1'b1,1'b0,1'b1,1'b1,PMS_BACKUP,DOM_BK,  0,0},  // Main lost
      '{1'b1,1'b1,1'b1,1'b1,PMS_FULL,  DOM_ALL, 1,0},  // Main back, hot
      '{1'b1,1'b0,1'b0,1'b0,PMS_RESET, DOM_NONE,0,0},  // All lost
      '{1'b1,1'b1,1'b1,1'b0,PMS_FULL,  DOM_ALL, 0,0}}; // Cold start

   always #5 ref_clk = ~ref_clk;             // 100 MHz clock

   pms_host_model i_host (.ref_clk(ref_clk), .runReq(runReq), .glitchLen(glitchLen), .powerReq(powerReq));
   power_mode_sequencer i_dut (.ref_clk(ref_clk), .srst(srst), .powerReq(powerReq),
      .external_reset_input_n(extRstN), .mainSupplyGood(mainGood), .backup_supply(bkGood),
      .autoLpEnable(autoLp), .fixDone(fixDone), .wakePeriod(wakePeriod), .domEn(domEn),
      .modeQ(modeQ), .saveStrobe(saveStrobe), .hotStart(hotStart), .retainValid(retainValid),
      .coreRstN(coreRstN));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Counts one-cycle pulses
   always @(posedge ref_clk) begin
      if (hotStart === 1'b1) hotCnt++;
      if (saveStrobe === 1'b1) saveCnt++;
   end

   // Compares and reports
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   // Waits for a mode, bounded; returns cycles spent
   task automatic wait_mode(input pms_mode_type m, input int lim, output int cyc);
      cyc = 0;
      while (modeQ !== m && cyc < lim) begin
         @(negedge ref_clk);
         cyc++;
      end
      if (cyc >= lim) check("wait mode", 32'(modeQ), 32'(m));
   endtask : wait_mode

   // Prints counts and verdict
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      report_and_stop();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      repeat (3) @(posedge ref_clk);
      check("rst mode", 32'(modeQ), 32'(PMS_RESET));
      check("rst core", 32'(coreRstN), 32'h0);
      srst <= 1'b0;
      // Table of supply and request changes
      for (i = 0; i < 7; i++) begin
         h0 = hotCnt;
         s0 = saveCnt;
         @(posedge ref_clk);
         runReq <= rows[i].run; mainGood <= rows[i].main; bkGood <= rows[i].bk;
         wait_mode(rows[i].mode, 400, n);
         repeat (3) @(negedge ref_clk);
         check("mode", 32'(modeQ), 32'(rows[i].mode));
         check("dom", 32'(domEn), 32'(rows[i].dom));
         check("retain", 32'(retainValid), 32'(rows[i].ret));
         check("hot", 32'(hotCnt - h0), 32'(rows[i].hot));
         check("save", 32'(saveCnt - s0), 32'(rows[i].save));
      end
      // Short glitch on the pin is ignored
      @(posedge ref_clk) glitchLen <= 8'h0C;
      @(posedge ref_clk) glitchLen <= 8'h00;
      repeat (40) @(negedge ref_clk);
      check("glitch", 32'(modeQ), 32'(PMS_FULL));
      // Sleep taken only after the stable time
      @(posedge ref_clk) runReq <= 1'b0;
      wait_mode(PMS_SAVE, 60, n);
      check("filter", 32'(n >= 20), 32'h1);
      @(posedge ref_clk) runReq <= 1'b1;
      wait_mode(PMS_FULL, 100, n);
      // Fix ignored while automatic mode is off
      @(posedge ref_clk) fixDone <= 1'b1;
      @(posedge ref_clk) fixDone <= 1'b0;
      repeat (10) @(negedge ref_clk);
      check("fix off", 32'(modeQ), 32'(PMS_FULL));
      // Automatic sleep and timed wake
      h0 = hotCnt;
      @(posedge ref_clk) autoLp <= 1'b1;
      @(posedge ref_clk) fixDone <= 1'b1;
      @(posedge ref_clk) fixDone <= 1'b0;
      wait_mode(PMS_AUTOLP, 10, n);
      check("auto mode", 32'(modeQ), 32'(PMS_AUTOLP));
      check("auto dom", 32'(domEn), 32'(DOM_LP));
      wait_mode(PMS_FULL, 80, n);
      check("wake time", 32'(n >= 45 && n <= 60), 32'h1);
      check("wake mode", 32'(modeQ), 32'(PMS_FULL));
      @(negedge ref_clk);
      check("wake hot", 32'(hotCnt - h0), 32'h1);
      // Request falling in automatic sleep hands over to the host
      @(posedge ref_clk) fixDone <= 1'b1;
      @(posedge ref_clk) fixDone <= 1'b0;
      wait_mode(PMS_AUTOLP, 10, n);
      @(posedge ref_clk) runReq <= 1'b0;
      wait_mode(PMS_EXTLP, 40, n);
      check("auto to ext", 32'(modeQ), 32'(PMS_EXTLP));
      @(posedge ref_clk) runReq <= 1'b1;
      wait_mode(PMS_FULL, 40, n);
      check("ext to full", 32'(modeQ), 32'(PMS_FULL));
      @(posedge ref_clk) autoLp <= 1'b0;
      // External reset pin
      @(posedge ref_clk) extRstN <= 1'b0;
      wait_mode(PMS_RESET, 10, n);
      check("ext core", 32'(coreRstN), 32'h0);
      check("ext dom", 32'(domEn), 32'(DOM_NONE));
      @(posedge ref_clk) extRstN <= 1'b1;
      wait_mode(PMS_FULL, 200, n);
      check("ext back", 32'(coreRstN), 32'h1);
      // Second reset in mid-run
      @(posedge ref_clk) srst <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check("srst mode", 32'(modeQ), 32'(PMS_RESET));
      @(posedge ref_clk) srst <= 1'b0;
      wait_mode(PMS_FULL, 200, n);
      check("srst back", 32'(domEn), 32'(DOM_ALL));
      report_and_stop();
   end
endmodule : power_mode_sequencer_tb
`default_nettype wire
